// ===== core/bsttc_cal_mem.sv
// Small memory holding phase calibration data items, read through a register
`timescale 1ns/100ps
module bsttc_cal_mem
	import bsttc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       wr_en,
	input  wire logic [3:0] wr_addr,
	input  wire logic [4:0] wr_data,
	input  wire logic [3:0] rd_addr,
	output logic      [4:0] rd_data
);
	typedef struct packed {
		logic [BSTTC_CAL_ITEMS-1:0][4:0] mem;  // Calibration items
		logic [4:0]                      rd;   // Registered read data
	} bsttc_mem_type;

	bsttc_mem_type st_ff;
	bsttc_mem_type nxt_st;

	// Write port and registered read
	always_comb begin
		nxt_st = st_ff;
		if (wr_en) begin
			nxt_st.mem[wr_addr] = wr_data;
		end
		nxt_st.rd = st_ff.mem[rd_addr];
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign rd_data = st_ff.rd;
endmodule

// ===== core/bsttc_pkg.sv
// Package with register map, field positions, reset values and timing of the boost control bank
// Operation
// R1 - Output on only in operation mode with enable
// R2 - Gate supply on when any output enabled
// R3 - Switch after start-up only if supply good
// R4 - Host writes zeros to reserved control bits
// R5 - Bit 0 selects lock or no lock
// R6 - Count select low time while enable set
// R7 - Clearing enable freezes count of that command
// R8 - Counter 16 bits, bytes at 41h/42h
// R9 - One count per trimmed oscillator period
// R10 - Host applies known low time, compares, trims
// R11 - Host repeats measurement until count matches
// R12 - Host sets loop factors max, checks supply
// R13 - Clearing 1Ch bit 0 starts calibration
// R14 - Calibration result readable at 4Ch
// R15 - Calibration mode uses default oscillator frequency
// R16 - Host restarts calibration only after completion
// R17 - Host repeats calibration, discards outliers
// R18 - Field 5:1 is trim or pointer
// R19 - Result register returns pointed calibration item
// R20 - Code 00100 default, steps of 2.78 %
// R21 - Counter restarts each fall, saturates
package bsttc_pkg;
	// Register addresses
	localparam logic [7:0] BSTTC_ADDR_FUNC_CTRL    = 8'h00;
	localparam logic [7:0] BSTTC_ADDR_TRIM_CAL     = 8'h1C;
	localparam logic [7:0] BSTTC_ADDR_CNT_LOW      = 8'h41;
	localparam logic [7:0] BSTTC_ADDR_CNT_HIGH     = 8'h42;
	localparam logic [7:0] BSTTC_ADDR_CAL_RESULT   = 8'h4C;
	// Function control field positions
	localparam int         BSTTC_FC_LOCK_BIT       = 0;
	localparam int         BSTTC_FC_OUT1_BIT       = 1;
	localparam int         BSTTC_FC_OUT2_BIT       = 2;
	localparam int         BSTTC_FC_CNT_BIT        = 3;
	localparam logic [7:0] BSTTC_FC_WRITE_MASK     = 8'h0F;
	// Trim and calibration field positions
	localparam int         BSTTC_TC_CALIB_BIT      = 0;
	localparam int         BSTTC_TC_FIELD_LSB      = 1;
	localparam logic [7:0] BSTTC_TC_WRITE_MASK     = 8'h3F;
	// Reset values and saturation limit
	localparam logic [7:0] BSTTC_FC_RESET          = 8'h00;
	localparam logic [7:0] BSTTC_TC_RESET          = 8'h09;
	localparam logic [4:0] BSTTC_TRIM_DEFAULT      = 5'h04;
	localparam logic [15:0] BSTTC_CNT_MAX          = 16'hFFFF;
	// Calibration result: bit 7 flags completion
	localparam int         BSTTC_CAL_DONE_BIT      = 7;
	localparam int         BSTTC_CAL_ITEMS         = 16;
	// Timing
	localparam int         BSTTC_CLK_MHZ           = 100;
	localparam int         BSTTC_GATE_START_US     = 10;
	localparam int         BSTTC_CALIB_US          = 100;
	localparam int         BSTTC_GATE_START_CYC    = BSTTC_GATE_START_US * BSTTC_CLK_MHZ;
	localparam int         BSTTC_CALIB_CYC         = BSTTC_CALIB_US * BSTTC_CLK_MHZ;
	// Calibration sequencer states
	typedef enum logic [2:0] {
		BSTTC_CAL_IDLE = 3'b001,
		BSTTC_CAL_RUN  = 3'b010,
		BSTTC_CAL_DONE = 3'b100
	} bsttc_cal_state_type;
endpackage

// ===== core/bsttc_top.sv
// Function control, select-low counter, trim and phase calibration register bank
`timescale 1ns/100ps
module bsttc_top
	import bsttc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       chip_select_n,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       operation_mode,
	input  wire logic       gate_supply_good,
	input  wire logic [4:0] cal_measure,
	output logic      [7:0] reg_rdata,
	output logic            output_one_on,
	output logic            output_two_on,
	output logic            gate_driver_supply_on,
	output logic            gate_switch_en,
	output logic      [4:0] osc_trim,
	output logic            configuration_done_lock,
	output logic            calibration_done
);
	typedef struct packed {
		logic [1:0]          cs_sync;   // Two-stage synchroniser for select
		logic                cs_prev;   // Previous synchronised level
		logic [7:0]          func_ctrl; // Function control register
		logic [7:0]          trim_cal;  // Trim and calibration register
		logic [15:0]         cnt;       // Running low-time count
		logic [15:0]         cnt_hold;  // Frozen visible count
		logic                cnt_arm;   // Counting during current frame
		logic                stop_pend; // Freeze after this frame
		logic [15:0]         gate_tmr;  // Gate start-up timer
		logic [15:0]         cal_tmr;   // Calibration timer
		logic [3:0]          cal_idx;   // Item being captured
		bsttc_cal_state_type cal_st;    // Calibration state
		logic [7:0]          rdata;
		logic                out1;
		logic                out2;
		logic                gsup;
		logic                gsw;
		logic [4:0]          trim;
	} bsttc_state_type;

	bsttc_state_type st_ff;
	bsttc_state_type nxt_st;
	logic            mem_wr;
	logic [4:0]      mem_rd;

	// Saturating increment used by the calibration timer and the counter
	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		sat_inc = (v == BSTTC_CNT_MAX) ? v : v + 16'h0001;
	endfunction

	assign mem_wr = (st_ff.cal_st == BSTTC_CAL_RUN) && (st_ff.cal_tmr[3:0] == 4'hF);

	bsttc_cal_mem u_mem (
		.clk     (clk),
		.rst     (rst),
		.ce      (ce),
		.wr_en   (mem_wr),
		.wr_addr (st_ff.cal_idx),
		.wr_data (cal_measure),
		.rd_addr (st_ff.trim_cal[4:1]),
		.rd_data (mem_rd)
	);

	// Next-state logic
	always_comb begin
		logic fall;
		logic rise;
		logic any_on;
		logic calib_mode;
		logic stop_set;
		stop_set = 1'b0;
		fall = 1'b0;
		rise = 1'b0;
		any_on = 1'b0;
		calib_mode = 1'b0;
		nxt_st = st_ff;
		nxt_st.cs_sync = {st_ff.cs_sync[0], chip_select_n};
		nxt_st.cs_prev = st_ff.cs_sync[1];
		fall = st_ff.cs_prev & ~st_ff.cs_sync[1];
		rise = ~st_ff.cs_prev & st_ff.cs_sync[1];
		// Register writes, reserved bits held at zero
		if (reg_wr && reg_addr == BSTTC_ADDR_FUNC_CTRL) begin
			nxt_st.func_ctrl = reg_wdata & BSTTC_FC_WRITE_MASK; // see R4, R5
			if (st_ff.func_ctrl[BSTTC_FC_CNT_BIT] && !reg_wdata[BSTTC_FC_CNT_BIT]) begin
				nxt_st.stop_pend = 1'b1; // see R7
				stop_set = 1'b1;
			end
		end
		if (reg_wr && reg_addr == BSTTC_ADDR_TRIM_CAL) begin
			nxt_st.trim_cal = reg_wdata & BSTTC_TC_WRITE_MASK; // see R18
			if (st_ff.trim_cal[BSTTC_TC_CALIB_BIT] && !reg_wdata[BSTTC_TC_CALIB_BIT]
				&& st_ff.cal_st != BSTTC_CAL_RUN) begin
				nxt_st.cal_st = BSTTC_CAL_RUN; // see R13
				nxt_st.cal_tmr = '0;
				nxt_st.cal_idx = '0;
			end
		end
		// Low-time counter, one tick per clock
		if (fall) begin
			nxt_st.cnt_arm = st_ff.func_ctrl[BSTTC_FC_CNT_BIT] | st_ff.stop_pend;
			nxt_st.cnt = '0; // see R21
		end else if (st_ff.cnt_arm && !st_ff.cs_sync[1]) begin
			nxt_st.cnt = sat_inc(st_ff.cnt); // see R6, R9, R21
		end
		if (rise && st_ff.cnt_arm) begin
			nxt_st.cnt_hold = st_ff.cnt; // see R7, R8
			nxt_st.cnt_arm = 1'b0;
			// A clearing write in the same cycle wins over the frame end
			if (!stop_set) begin
				nxt_st.stop_pend = 1'b0;
			end
		end
		// Calibration sequencer
		unique case (st_ff.cal_st)
			BSTTC_CAL_IDLE: begin
			end
			BSTTC_CAL_RUN: begin
				nxt_st.cal_tmr = sat_inc(st_ff.cal_tmr);
				if (mem_wr) begin
					nxt_st.cal_idx = st_ff.cal_idx + 4'h1;
				end
				if (st_ff.cal_tmr >= 16'(BSTTC_CALIB_CYC - 1)) begin
					nxt_st.cal_st = BSTTC_CAL_DONE; // see R13
				end
			end
			BSTTC_CAL_DONE: begin
				if (reg_wr && reg_addr == BSTTC_ADDR_TRIM_CAL && reg_wdata[BSTTC_TC_CALIB_BIT]) begin
					nxt_st.cal_st = BSTTC_CAL_IDLE;
				end
			end
		endcase
		// Output enables and gate driver supply
		nxt_st.out1 = operation_mode & st_ff.func_ctrl[BSTTC_FC_OUT1_BIT]; // see R1
		nxt_st.out2 = operation_mode & st_ff.func_ctrl[BSTTC_FC_OUT2_BIT]; // see R1
		any_on = st_ff.out1 | st_ff.out2;
		nxt_st.gsup = any_on; // see R2
		if (!any_on) begin
			nxt_st.gate_tmr = '0;
		end else if (st_ff.gate_tmr < 16'(BSTTC_GATE_START_CYC)) begin
			nxt_st.gate_tmr = st_ff.gate_tmr + 16'h0001;
		end
		nxt_st.gsw = any_on && (st_ff.gate_tmr >= 16'(BSTTC_GATE_START_CYC)) && gate_supply_good; // see R3
		// Oscillator trim selection
		calib_mode = ~st_ff.trim_cal[BSTTC_TC_CALIB_BIT];
		nxt_st.trim = calib_mode ? BSTTC_TRIM_DEFAULT : st_ff.trim_cal[5:1]; // see R15, R20
		// Read data
		unique case (reg_addr)
			BSTTC_ADDR_FUNC_CTRL:  nxt_st.rdata = st_ff.func_ctrl;
			BSTTC_ADDR_TRIM_CAL:   nxt_st.rdata = st_ff.trim_cal;
			BSTTC_ADDR_CNT_LOW:    nxt_st.rdata = st_ff.cnt_hold[7:0];  // see R8
			BSTTC_ADDR_CNT_HIGH:   nxt_st.rdata = st_ff.cnt_hold[15:8]; // see R8
			BSTTC_ADDR_CAL_RESULT: begin
				nxt_st.rdata = {(st_ff.cal_st == BSTTC_CAL_DONE), 2'b00, mem_rd}; // see R14, R19
			end
			default:               nxt_st.rdata = 8'h00;
		endcase
		if (!reg_rd) begin
			nxt_st.rdata = st_ff.rdata;
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_ff           <= '0;
			st_ff.cs_sync   <= 2'b11;
			st_ff.cs_prev   <= 1'b1;
			st_ff.func_ctrl <= BSTTC_FC_RESET;
			st_ff.trim_cal  <= BSTTC_TC_RESET;
			st_ff.cal_st    <= BSTTC_CAL_IDLE;
			st_ff.trim      <= BSTTC_TRIM_DEFAULT;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata               = st_ff.rdata;
	assign output_one_on           = st_ff.out1;
	assign output_two_on           = st_ff.out2;
	assign gate_driver_supply_on   = st_ff.gsup;
	assign gate_switch_en          = st_ff.gsw;
	assign osc_trim                = st_ff.trim;
	assign configuration_done_lock = st_ff.func_ctrl[BSTTC_FC_LOCK_BIT]; // see R5
	// One-hot done code, so the output is a flop bit
	assign calibration_done        = st_ff.cal_st[2];
endmodule

// ===== test/bsttc_host_model.sv
// Host model that frames chip select for accurately known low times
`timescale 1ns/100ps
module bsttc_host_model (
	output logic chip_select_n
);
	// Select idles high between frames
	initial chip_select_n = 1'h1;
	// Low for whole link clock periods of 125 ns, repeated per measurement
	task automatic frame(input int bits);
		chip_select_n = 1'h0;
		#(bits * 125);
		chip_select_n = 1'h1;
		#250;
	endtask
endmodule

// ===== test/bsttc_monitor.sv
// Checker of the control bank port relations, bound onto the top module
`timescale 1ns/100ps
module bsttc_monitor
	import bsttc_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       ce,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       operation_mode,
	input wire logic       gate_supply_good,
	input wire logic       output_one_on,
	input wire logic       output_two_on,
	input wire logic       gate_driver_supply_on,
	input wire logic       gate_switch_en,
	input wire logic [4:0] osc_trim,
	input wire logic       configuration_done_lock,
	input wire logic       calibration_done
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Write strobes of the two control registers
	wire        fc_w = reg_wr && ce && reg_addr == BSTTC_ADDR_FUNC_CTRL;
	wire        tc_w = reg_wr && ce && reg_addr == BSTTC_ADDR_TRIM_CAL;
	logic [7:0] wd_ff;
	// Last write data, so the lock check needs no bit-select inside a past value
	always_ff @(posedge clk) wd_ff <= reg_wdata;
	// Calibration launch from idle, then a quiet stretch
	sequence s_cal_start; tc_w && !reg_wdata[0] && !calibration_done; endsequence
	sequence s_no_done; !calibration_done [*8]; endsequence
	a_one_mode: assert property ($rose(output_one_on) |-> $past(operation_mode))
		else $error("output one on outside operation mode");
	a_two_mode: assert property ($rose(output_two_on) |-> $past(operation_mode))
		else $error("output two on outside operation mode");
	a_supply_on: assert property ($rose(output_one_on) || $rose(output_two_on) |-> ##[0:2] gate_driver_supply_on)
		else $error("gate supply not on with an output");
	a_switch_good: assert property ($rose(gate_switch_en) |-> $past(gate_supply_good) && gate_driver_supply_on)
		else $error("switching started without good supply");
	a_switch_wait: assert property ($rose(gate_driver_supply_on) |=> !gate_switch_en [*8])
		else $error("switching started before start-up time");
	a_lock_bit: assert property (fc_w |=> configuration_done_lock == wd_ff[0])
		else $error("lock bit differs from written bit 0");
	a_trim_field: assert property (tc_w && reg_wdata[0] |=> ##1 osc_trim == $past(wd_ff[5:1]))
		else $error("trim output differs from written field");
	a_cal_default: assert property (tc_w && !reg_wdata[0] |=> ##1 osc_trim == BSTTC_TRIM_DEFAULT)
		else $error("trim not default in calibration mode");
	a_cal_time: assert property (s_cal_start |=> s_no_done)
		else $error("calibration done too early");
endmodule
bind bsttc_top bsttc_monitor i_mon (.clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .operation_mode(operation_mode), .gate_supply_good(gate_supply_good),
	.output_one_on(output_one_on), .output_two_on(output_two_on), .gate_driver_supply_on(gate_driver_supply_on),
	.gate_switch_en(gate_switch_en), .osc_trim(osc_trim), .configuration_done_lock(configuration_done_lock),
	.calibration_done(calibration_done));

// ===== test/testbench.sv
// Self-checking bench of the boost control register bank
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench
	import bsttc_pkg::*;
;
	logic        clk, rst, ce, reg_wr, reg_rd, operation_mode, gate_supply_good;
	logic        one_on, two_on, supply_on, switch_en, lock, cal_done;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_val;
	logic [4:0]  osc_trim;
	logic [15:0] cnt;
	logic [23:0] rows [7] = '{24'h000101, 24'h000505, 24'h000000, 24'h1C3F3F, 24'h1C0909, 24'h415500, 24'h507700};
	wire         chip_select_n;
	int          fail_count, n_tests, k, j;
	bsttc_top i_dut (.clk(clk), .rst(rst), .ce(ce), .chip_select_n(chip_select_n), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .operation_mode(operation_mode),
		.gate_supply_good(gate_supply_good), .cal_measure(5'h15), .reg_rdata(reg_rdata), .output_one_on(one_on),
		.output_two_on(two_on), .gate_driver_supply_on(supply_on), .gate_switch_en(switch_en),
		.osc_trim(osc_trim), .configuration_done_lock(lock), .calibration_done(cal_done));
	bsttc_host_model i_host (.chip_select_n(chip_select_n));
	// 100 MHz clock
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task automatic cyc(input int n); repeat (n) @(negedge clk); endtask
	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'h1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'h0;
	endtask
	// One-cycle read strobe, data taken once it has settled
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		reg_rd = 1'h1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'h0;
		@(negedge clk);
		rd_val = reg_rdata;
	endtask
	// Both count bytes, allowing two ticks of select synchroniser slack
	task automatic chk_cnt(input logic [15:0] exp);
		rd(BSTTC_ADDR_CNT_LOW);
		cnt[7:0] = rd_val;
		rd(BSTTC_ADDR_CNT_HIGH);
		cnt[15:8] = rd_val;
		`CHK(cnt >= exp - 16'h2 && cnt <= exp + 16'h2, 1'h1)
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog far beyond the expected run of about 23000 cycles
	initial begin
		#500000;
		fail_count++;
		report_and_stop();
	end
	// Main sequence
	initial begin
		{rst, reg_wr, reg_rd, operation_mode, gate_supply_good} = 5'h10;
		{reg_addr, reg_wdata} = 16'h0000;
		ce = 1'h1;
		cyc(6);
		rst = 1'h0;
		rd(BSTTC_ADDR_TRIM_CAL);
		`CHK(rd_val, 8'h09)
		`CHK({osc_trim, one_on, two_on, supply_on, switch_en, lock, cal_done}, 11'h100)
		for (k = 0; k < 7; k++) begin
			wr(rows[k][23:16], rows[k][15:8]);
			rd(rows[k][23:16]);
			`CHK(rd_val, rows[k][7:0])
		end
		wr(8'h00, 8'h06);
		cyc(5);
		`CHK({one_on, two_on, supply_on}, 3'h0)
		operation_mode = 1'h1;
		cyc(1100);
		`CHK({one_on, two_on, supply_on, switch_en}, 4'hE)
		gate_supply_good = 1'h1;
		cyc(5);
		`CHK(switch_en, 1'h1)
		wr(8'h00, 8'h04);
		cyc(5);
		`CHK({one_on, two_on, supply_on}, 3'h3)
		wr(8'h00, 8'h00);
		cyc(5);
		`CHK({supply_on, switch_en}, 2'h0)
		wr(8'h00, 8'h02);
		cyc(980);
		`CHK({supply_on, switch_en}, 2'h2)
		cyc(40);
		`CHK(switch_en, 1'h1)
		wr(8'h00, 8'h08);
		i_host.frame(16);
		chk_cnt(16'h00C8);
		fork
			i_host.frame(40);
			begin
				cyc(100);
				wr(8'h00, 8'h00);
			end
		join
		i_host.frame(8);
		chk_cnt(16'h01F4);
		// Two calibration runs with good gate supply, results compared
		for (j = 0; j < 2; j++) begin
			wr(BSTTC_ADDR_TRIM_CAL, 8'h3F);
			wr(BSTTC_ADDR_TRIM_CAL, 8'h08);
			cyc(2);
			`CHK(osc_trim, 5'h04)
			rd(BSTTC_ADDR_CAL_RESULT);
			`CHK(rd_val[7], 1'h0)
			for (k = 0; cal_done !== 1'h1 && k < 32'h2AF8; k++)
				cyc(1);
			`CHK(k > 32'h26AC && k < 32'h271A, 1'h1)
			rd(BSTTC_ADDR_CAL_RESULT);
			`CHK(rd_val[7], 1'h1)
			`CHK(rd_val, 8'h95)
		end
		wr(BSTTC_ADDR_TRIM_CAL, 8'h3F);
		cyc(2);
		`CHK({cal_done, osc_trim}, 6'h1F)
		// Clock enable low freezes state, so the write is lost
		ce = 1'h0;
		wr(BSTTC_ADDR_TRIM_CAL, 8'h09);
		ce = 1'h1;
		rd(BSTTC_ADDR_TRIM_CAL);
		`CHK(rd_val, 8'h3F)
		report_and_stop();
	end
endmodule
